// *** src/fwd_ctl_defs.vh ***
// Purpose: offsets, field positions, reset values for forwarding control
// Assumes: byte addresses are four times the printed index
// Notes: included by both design files
`ifndef FWD_CTL_DEFS_VH
`define FWD_CTL_DEFS_VH

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define IDX_CLK_CTL 8'h1f
`define IDX_PORT_DIS 8'h20
`define IDX_MODE_CTL 8'h21
`define ADDR_W 10
`define ADDR_CLK_CTL 10'h07c
`define ADDR_PORT_DIS 10'h080
`define ADDR_MODE_CTL 10'h084
`define ADDR_STATUS 10'h088

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define RST_CLK_CTL 8'h02
`define RST_PORT_DIS 8'hf0
`define RST_MODE_CTL 8'h03
`define MASK_CLK_CTL 8'h0f
`define MASK_PORT_DIS 8'hf0
`define MASK_MODE_CTL 8'h4d

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_OSC_SEL 3
`define BIT_REF_MODE 2
`define SPEED_HI 1
`define SPEED_LO 0
`define BLOCK_HI 7
`define BLOCK_LO 4
`define BIT_WHEN_READY 6
`define SYNC_HI 3
`define SYNC_LO 2
`define BIT_RR 0

// ----------------------------------------
// encodings
// ----------------------------------------
`define SYNC_OFF 2'h0
`define SYNC_BASIC 2'h1
`define SYNC_INTERLEAVE 2'h2
`define SYNC_CONCAT 2'h3
`define SPEED_SLOW 2'h3
`define NPORTS 4

`endif

// *** src/port_grant_gate.v ***
// Purpose: per-port decision whether a line may be forwarded
// Assumes: inputs on i_mclk domain
// Notes: one instance per receive port
`include "fwd_ctl_defs.vh"

module port_grant_gate (
	input wire i_block,
	input wire i_ready,
	input wire i_all_ready,
	input wire i_sync_on,
	input wire i_when_ready,
	input wire i_long_pkt,
	output wire o_may_send
);
	wire sync_wait;
	assign sync_wait = i_sync_on & ~(i_when_ready & i_long_pkt);
	assign o_may_send = ~i_block & i_ready & (~sync_wait | i_all_ready);
endmodule // port_grant_gate

// *** src/forward_control.v ***
// Purpose: clock and forwarding control registers, forwarding arbiter
// Assumes: avalon-mm slave, one wait cycle on every access
// Notes: line ready inputs come from same-clock receive logic
`include "fwd_ctl_defs.vh"

module forward_control #(
	parameter NP = `NPORTS
) (
	input wire i_mclk,
	input wire i_rst,
	input wire [`ADDR_W-1:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	output reg [31:0] o_readdata,
	output reg o_waitrequest,
	input wire [NP-1:0] i_line_ready,
	input wire [NP-1:0] i_long_pkt,
	input wire i_line_done,
	output reg o_osc_internal,
	output reg o_ref_half_rate,
	output reg [1:0] o_tx_speed,
	output reg [1:0] o_sync_mode,
	output reg [NP-1:0] o_grant,
	output reg o_grant_valid
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] clk_ctl_reg;
	reg [7:0] port_dis_reg;
	reg [7:0] mode_ctl_reg;
	reg ack_reg;
	reg busy_reg;
	reg [NP-1:0] last_reg;
	reg [NP-1:0] pick_next;
	reg [31:0] rd_next;
	wire [NP-1:0] may_send;
	wire [NP-1:0] block;
	wire [NP-1:0] need;
	wire all_ready;
	wire sync_on;
	wire rr_on;
	wire when_ready;
	wire [1:0] sync_mode;
	wire access;
	integer k;
	integer j;

	assign access = (i_read | i_write) & ~ack_reg;
	assign block = port_dis_reg[`BLOCK_HI:`BLOCK_LO];
	assign sync_mode = mode_ctl_reg[`SYNC_HI:`SYNC_LO];
	assign sync_on = (sync_mode != `SYNC_OFF);
	assign rr_on = mode_ctl_reg[`BIT_RR] & ~sync_on;
	assign when_ready = mode_ctl_reg[`BIT_WHEN_READY] &
		(sync_mode != `SYNC_CONCAT);
	assign need = ~block;
	assign all_ready = ((i_line_ready & need) == need) & (|need);

	// ----------------------------------------
	// per-port gates
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NP; g = g + 1) begin : gates
			port_grant_gate u_gate (
				.i_block(block[g]),
				.i_ready(i_line_ready[g]),
				.i_all_ready(all_ready),
				.i_sync_on(sync_on),
				.i_when_ready(when_ready),
				.i_long_pkt(i_long_pkt[g]),
				.o_may_send(may_send[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// reserved bits zero
	always @* begin
		rd_next = 32'h00000000;
		case (i_address)
		`ADDR_CLK_CTL: rd_next[7:0] = clk_ctl_reg;
		`ADDR_PORT_DIS: rd_next[7:0] = port_dis_reg;
		`ADDR_MODE_CTL: rd_next[7:0] = mode_ctl_reg;
		`ADDR_STATUS: rd_next[NP:0] = {busy_reg, i_line_ready};
		default: rd_next = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	always @(posedge i_mclk) begin
		if (i_rst) begin
			clk_ctl_reg <= `RST_CLK_CTL;
			port_dis_reg <= `RST_PORT_DIS;
			// reserved bit of the reset value reads zero
			mode_ctl_reg <= `RST_MODE_CTL & `MASK_MODE_CTL;
			ack_reg <= 1'b0;
			o_waitrequest <= 1'b1;
			o_readdata <= 32'h00000000;
		end else begin
			// waitrequest drops one cycle after request
			ack_reg <= access;
			o_waitrequest <= ~access;
			if (access && i_read)
				o_readdata <= rd_next;
			// write lands at the edge that sees waitrequest low
			if (ack_reg && i_write) begin
				case (i_address)
				`ADDR_CLK_CTL:
					clk_ctl_reg <= i_writedata[7:0] & `MASK_CLK_CTL;
				`ADDR_PORT_DIS:
					port_dis_reg <= i_writedata[7:0] & `MASK_PORT_DIS;
				`ADDR_MODE_CTL:
					mode_ctl_reg <= i_writedata[7:0] & `MASK_MODE_CTL;
				default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// clock, speed and sync mode outputs
	// ----------------------------------------
	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_osc_internal <= 1'b0;
			o_ref_half_rate <= 1'b0;
			o_tx_speed <= 2'h2;
			o_sync_mode <= 2'h0;
		end else begin
			o_osc_internal <= clk_ctl_reg[`BIT_OSC_SEL];
			o_ref_half_rate <= clk_ctl_reg[`BIT_REF_MODE];
			o_tx_speed <= clk_ctl_reg[`SPEED_HI:`SPEED_LO];
			o_sync_mode <= sync_mode;
		end
	end

	// ----------------------------------------
	// arbiter
	// ----------------------------------------
	// round robin from last
	always @* begin
		pick_next = {NP{1'b0}};
		j = 0;
		for (k = 1; k <= NP; k = k + 1) begin
			j = k;
			if (pick_next == {NP{1'b0}} &&
				may_send[(j + idx(last_reg)) % NP])
				pick_next[(j + idx(last_reg)) % NP] = 1'b1;
		end
	end

	function integer idx;
		input [NP-1:0] v;
		integer m;
		begin
			idx = 0;
			for (m = 0; m < NP; m = m + 1)
				if (v[m]) idx = m;
		end
	endfunction

	// one line in flight; i_line_done frees the output
	always @(posedge i_mclk) begin
		if (i_rst) begin
			last_reg <= {{(NP-1){1'b0}}, 1'b1} << (NP - 1);
			busy_reg <= 1'b0;
			o_grant <= {NP{1'b0}};
			o_grant_valid <= 1'b0;
		end else if (busy_reg) begin
			if (i_line_done) begin
				busy_reg <= 1'b0;
				o_grant <= {NP{1'b0}};
				o_grant_valid <= 1'b0;
			end
		end else if ((rr_on | sync_on) && (|pick_next)) begin
			busy_reg <= 1'b1;
			last_reg <= pick_next;
			o_grant <= pick_next;
			o_grant_valid <= 1'b1;
		end
	end

endmodule // forward_control

// *** bench/fwd_chk.sv ***
// Purpose: port checks of forward_control
// Assumes: one wait cycle on every access
// Notes: field outputs settle two edges after the ack
`include "fwd_ctl_defs.vh"
module fwd_chk #(
	parameter NP = 4
) (
	input wire i_mclk,
	input wire i_rst,
	input wire [`ADDR_W-1:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [31:0] o_readdata,
	input wire o_waitrequest,
	input wire [NP-1:0] i_line_ready,
	input wire [NP-1:0] i_long_pkt,
	input wire i_line_done,
	input wire o_osc_internal,
	input wire o_ref_half_rate,
	input wire [1:0] o_tx_speed,
	input wire [1:0] o_sync_mode,
	input wire [NP-1:0] o_grant,
	input wire o_grant_valid
);
timeunit 1ns;
timeprecision 1ns;
// --------
// checks
// --------
default clocking @(posedge i_mclk); endclocking
default disable iff (i_rst);
a_req_ack: assert property ($rose(i_read | i_write) |=> !o_waitrequest)
	else $error("no ack");
a_ack_one: assert property (!o_waitrequest |=> o_waitrequest)
	else $error("long ack");
a_clk_fields: assert property (!o_waitrequest && i_write &&
	i_address == `ADDR_CLK_CTL |=> ##1 {o_osc_internal, o_ref_half_rate,
	o_tx_speed} == $past(i_writedata[3:0], 2)) else $error("clk field");
a_mode_field: assert property (!o_waitrequest && i_write &&
	i_address == `ADDR_MODE_CTL |=> ##1
	o_sync_mode == $past(i_writedata[3:2], 2)) else $error("mode field");
a_grant_hot: assert property (o_grant_valid |-> $onehot(o_grant))
	else $error("grant not one-hot");
a_grant_hold: assert property (o_grant_valid && !i_line_done |=>
	o_grant_valid && $stable(o_grant)) else $error("grant dropped");
a_grant_end: assert property (o_grant_valid && i_line_done |=>
	!o_grant_valid) else $error("grant kept");
a_grant_cause: assert property ($rose(o_grant_valid) |->
	|(o_grant & $past(i_line_ready))) else $error("grant unready");
c_grant: cover property ($rose(o_grant_valid));
c_done: cover property (o_grant_valid && i_line_done);
c_read: cover property (i_read && !o_waitrequest);
endmodule // fwd_chk
bind forward_control fwd_chk #(.NP(NP)) chk (.*);

// *** bench/rx_ports.sv ***
// Purpose: four receive ports and the line sink
// Assumes: a granted line ends on its third cycle
// Notes: ready lines are loaded by the bench
module rx_ports (
	input wire i_mclk,
	input wire i_rst,
	input wire i_load,
	input wire [3:0] i_avail,
	input wire [3:0] i_long,
	input wire [3:0] i_grant,
	input wire i_grant_valid,
	output logic [3:0] o_line_ready,
	output wire [3:0] o_long_pkt,
	output logic o_line_done
);
timeunit 1ns;
timeprecision 1ns;
// --------
// line sink
// --------
logic [1:0] cnt_reg;
wire fin = i_grant_valid && cnt_reg == 2'h2;
assign o_long_pkt = i_long;
always @(posedge i_mclk) begin
	if (i_rst) begin
		o_line_ready <= 4'h0;
		cnt_reg <= 2'h0;
		o_line_done <= 1'b0;
	end else begin
		o_line_done <= fin;
		// one done per grant, so a held grant is not paid twice
		cnt_reg <= (i_grant_valid && !o_line_done && !fin) ?
			cnt_reg + 2'h1 : 2'h0;
		o_line_ready <= (o_line_ready | (i_load ? i_avail : 4'h0)) &
			~(fin ? i_grant : 4'h0);
	end
end
endmodule // rx_ports

// *** bench/forward_control_tb.sv ***
// Purpose: register and forwarding tests
// Assumes: partner rx_ports in place of the ports
// Notes: no-grant cases watch a fixed window
module forward_control_tb;
timeunit 1ns;
timeprecision 1ns;
// --------
// bench
// --------
logic i_mclk = 0, i_rst = 1, i_read = 0, i_write = 0, ld = 0;
logic o_waitrequest, i_line_done, o_osc_internal, o_ref_half_rate;
logic o_grant_valid;
logic [1:0] o_tx_speed, o_sync_mode;
logic [3:0] i_line_ready, i_long_pkt, o_grant, av = 0, lg = 4'hf;
logic [3:0] seen = 0;
logic [9:0] i_address = 10'h000;
logic [31:0] i_writedata = 32'h0, o_readdata;
logic [7:0] rd;
wire [7:0] outs = {2'h0, o_sync_mode, o_osc_internal, o_ref_half_rate,
	o_tx_speed};
int failures = 0, check_count = 0, cyc = 0;
forward_control uut (.*);
rx_ports far (.i_mclk, .i_rst, .i_load(ld), .i_avail(av), .i_long(lg),
	.i_grant(o_grant), .i_grant_valid(o_grant_valid),
	.o_line_ready(i_line_ready), .o_long_pkt(i_long_pkt),
	.o_line_done(i_line_done));
initial forever #5 i_mclk = ~i_mclk;
task automatic end_of_test;
	$display("checks %0d mismatches %0d", check_count, failures);
	if (failures == 0 && check_count > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
always @(posedge i_mclk) begin
	seen <= ld ? 4'h0 : seen | (o_grant_valid ? o_grant : 4'h0);
	cyc <= cyc + 1;
	if (cyc == 5000) begin
		failures++;
		end_of_test;
	end
end
task automatic chk(input logic [7:0] got, exp);
	check_count++;
	if (got !== exp) begin
		failures++;
		$display("MISMATCH %0t got %h want %h", $time, got, exp);
	end
endtask
task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
	@(posedge i_mclk);
	i_address <= a;
	i_writedata <= {24'h0, d};
	i_write <= w;
	i_read <= !w;
	do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
	rd = o_readdata[7:0];
	i_write <= 0;
	i_read <= 0;
endtask
task automatic rdc(input logic [9:0] a, input logic [7:0] e);
	bus(0, a, 8'h00);
	chk(rd, e);
endtask
task automatic feed(input logic [3:0] v);
	@(posedge i_mclk);
	ld <= 1;
	av <= v;
	@(posedge i_mclk);
	ld <= 0;
	repeat (30) @(posedge i_mclk);
endtask
initial begin
	repeat (4) @(posedge i_mclk);
	i_rst <= 0;
	chk(outs, 8'h02);
	rdc(10'h07c, 8'h02);
	rdc(10'h080, 8'hf0);
	rdc(10'h084, 8'h01);
	rdc(10'h3fc, 8'h00);
	bus(1, 10'h07c, 8'hf9);
	rdc(10'h07c, 8'h09);
	chk(outs, 8'h09);
	bus(1, 10'h07c, 8'h06);
	repeat (2) @(posedge i_mclk);
	chk(outs, 8'h06);
	$display("clock control test done");
	feed(4'hf);
	chk({4'h0, seen}, 8'h00);
	bus(1, 10'h080, 8'h5f);
	rdc(10'h080, 8'h50);
	repeat (30) @(posedge i_mclk);
	chk({4'h0, seen}, 8'h0a);
	$display("round robin test done");
	bus(1, 10'h084, 8'h4c);
	bus(1, 10'h080, 8'h00);
	feed(4'h0);
	chk({4'h0, seen}, 8'h00);
	chk(outs, 8'h36);
	bus(1, 10'h084, 8'h44);
	repeat (30) @(posedge i_mclk);
	chk({4'h0, seen}, 8'h05);
	lg <= 4'h0;
	feed(4'h2);
	chk({4'h0, seen}, 8'h00);
	bus(1, 10'h084, 8'h04);
	repeat (30) @(posedge i_mclk);
	chk({4'h0, seen}, 8'h00);
	feed(4'hd);
	chk({7'h0, |seen}, 8'h01);
	$display("sync test done");
	end_of_test;
end
endmodule // forward_control_tb
